// >>> include/adcs_pkg.sv
package adcs_pkg;

   // Conversion sequencer states, one-hot.
   typedef enum logic [2:0] {
      ADCS_IDLE = 3'b001,
      ADCS_PEND = 3'b010,
      ADCS_CONV = 3'b100
   } adcs_state_t;

   // Channel and reference selection travel together.
   typedef struct packed {
      logic [1:0] ref_code;
      logic [4:0] chan;
   } adcs_sel_t;

   // Software control bits of the control register.
   typedef struct packed {
      logic en;
      logic auto_trig;
      logic ie;
      logic [2:0] ps;
   } adcs_ctrl_t;

endpackage

// >>> include/adcs_regs.svh
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH

// Register offsets on the plain register port.
`define ADCS_SEL_ADDR 8'h00
`define ADCS_CTRL_ADDR 8'h01
`define ADCS_TRIG_ADDR 8'h02
`define ADCS_APPLIED_ADDR 8'h03
`define ADCS_RES_LO_ADDR 8'h04
`define ADCS_RES_HI_ADDR 8'h05

// Selection register fields.
`define ADCS_SEL_REF_MSB 7
`define ADCS_SEL_REF_LSB 6
`define ADCS_SEL_CHAN_MSB 4
`define ADCS_SEL_CHAN_LSB 0

// Control and status register fields.
`define ADCS_CTRL_EN 7
`define ADCS_CTRL_START 6
`define ADCS_CTRL_AUTO 5
`define ADCS_CTRL_DONE 4
`define ADCS_CTRL_IE 3
`define ADCS_CTRL_PS_MSB 2
`define ADCS_CTRL_PS_LSB 0

// Trigger register field: 0 chains on completion, 1 uses the trigger pin.
`define ADCS_TRIG_SRC 0

// Reset values.
`define ADCS_SEL_RESET 8'h00
`define ADCS_CTRL_RESET 8'h00
`define ADCS_TRIG_RESET 8'h00

// Reference codes.
`define ADCS_REF_PIN 2'h0
`define ADCS_REF_SUPPLY 2'h1
`define ADCS_REF_BANDGAP 2'h3

// Sleep mode codes reported by the core.
`define ADCS_SLEEP_IDLE 3'h0
`define ADCS_SLEEP_NOISE 3'h1

// Conversion timing in converter clock cycles.
`define ADCS_CONV_CYCLES 5'h0d
`define ADCS_FIRST_CYCLES 5'h19
`define ADCS_SH_NORMAL 5'h01
`define ADCS_SH_FIRST 5'h0d

// Result code forced for an input above the reference.
`define ADCS_FULL_SCALE 10'h3ff

`endif

// >>> test/adcs_analog_model.sv
`timescale 1ns/1ps
`default_nettype none

// Analog front end: it samples the applied channel at the hold pulse.
module adcs_analog_model #(
   parameter logic [4:0] OVER_CH = 5'h1e
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Converter side.
   input wire logic [4:0] chan_sel,
   input wire logic sample_hold,
   output logic [9:0] analog_result,
   output logic over_range
);
   logic [4:0] held;

   // The input stays quiet after sampling, so the code is stable at completion.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         held <= 5'h00;
      end else if (sample_hold) begin
         held <= chan_sel;
      end
   end

   // Each channel gives its own code, so a stale channel shows in the result.
   assign analog_result = {3'h2, held, 2'h1};
   assign over_range = (held == OVER_CH);
endmodule

`default_nettype wire

// >>> test/adcs_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcs_regs.svh"

module adcs_ctrl_tb;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic cpu_halted = 1'b0;
   logic [2:0] sleep_mode = 3'h0;
   logic irq;
   logic trigger_pin = 1'b0;
   logic [9:0] analog_result;
   logic over_range;
   logic [4:0] chan_sel;
   logic ref_supply_en;
   logic ref_bandgap_en;
   logic ref_pin_en;
   logic sample_hold;
   logic conv_busy;
   logic [7:0] v;
   int n_fail = 0;
   int cmp_count = 0;
   int cycles = 0;
   int i;

   // Half period of the 200 MHz clock.
   always #2.5 clock = ~clock;

   adcs_ctrl u_adcs_ctrl (
      .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .cpu_halted(cpu_halted), .sleep_mode(sleep_mode), .irq(irq),
      .trigger_pin(trigger_pin), .analog_result(analog_result), .over_range(over_range),
      .chan_sel(chan_sel), .ref_supply_en(ref_supply_en), .ref_bandgap_en(ref_bandgap_en),
      .ref_pin_en(ref_pin_en), .sample_hold(sample_hold), .conv_busy(conv_busy)
   );

   adcs_analog_model u_adcs_analog_model (
      .clock(clock), .rst(rst), .chan_sel(chan_sel), .sample_hold(sample_hold),
      .analog_result(analog_result), .over_range(over_range)
   );

   // Comparisons of byte values and of single flags.
   task chk_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task chk_bit(input string name, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %b seen %b", name, exp, got);
      end
   endtask

   // Bus cycles: a gap cycle follows each strobe so no strobe is driven twice at one edge.
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   task rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
      rd_reg(a, v);
      chk_reg(name, exp, v);
   endtask

   // The model's code for a channel.
   function automatic logic [9:0] res_of(input logic [4:0] ch);
      return {3'h2, ch, 2'h1};
   endfunction

   task chk_res(input logic [9:0] exp);
      rd_chk("result low", `ADCS_RES_LO_ADDR, exp[7:0]);
      rd_chk("result high", `ADCS_RES_HI_ADDR, {6'h00, exp[9:8]});
   endtask

   // Polling is bounded well above the longest conversion.
   task wait_done;
      v = 8'h00;
      for (int k = 0; k < 100 && v[`ADCS_CTRL_DONE] !== 1'b1; k++) begin
         rd_reg(`ADCS_CTRL_ADDR, v);
      end
      chk_bit("done flag", 1'b1, v[`ADCS_CTRL_DONE]);
   endtask

   task wait_irq;
      for (int k = 0; k < 200 && irq !== 1'b1; k++) begin
         @(posedge clock);
         #1;
      end
      #1 chk_bit("irq", 1'b1, irq);
   endtask

   task finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // The whole sequence needs a few hundred cycles; a hang ends the run.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         finish_test;
      end
   end

   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      rd_chk("select reset", `ADCS_SEL_ADDR, 8'h00);
      rd_chk("ctrl reset", `ADCS_CTRL_ADDR, 8'h00);
      rd_chk("applied reset", `ADCS_APPLIED_ADDR, 8'h00);
      wr_reg(8'h07, 8'hff);
      rd_chk("unmapped", 8'h07, 8'h00);
      wr_reg(`ADCS_SEL_ADDR, 8'h45);
      rd_chk("select", `ADCS_SEL_ADDR, 8'h45);
      rd_chk("applied idle", `ADCS_APPLIED_ADDR, 8'h45);
      // Every reference code with the converter enabled.
      wr_reg(`ADCS_CTRL_ADDR, 8'h80);
      for (i = 0; i < 4; i++) begin
         wr_reg(`ADCS_SEL_ADDR, {i[1:0], 6'h05});
         repeat (2) @(posedge clock);
         #1 chk_bit("supply ref", i == 1, ref_supply_en);
         chk_bit("bandgap ref", i == 3, ref_bandgap_en);
         chk_bit("pin ref", i == 0 || i == 2, ref_pin_en);
      end
      // The reference moves back to the supply, so the first result after it is thrown away.
      wr_reg(`ADCS_SEL_ADDR, 8'h45);
      wr_reg(`ADCS_CTRL_ADDR, 8'hc0);
      wait_done;
      // Single conversion with a selection written into the locked window.
      wr_reg(`ADCS_CTRL_ADDR, 8'hd0);
      #1 chk_bit("busy on start write", 1'b0, conv_busy);
      rd_chk("start bit", `ADCS_CTRL_ADDR, 8'hc0);
      repeat (8) @(posedge clock);
      #1 chk_reg("applied channel", 8'h05, {3'h0, chan_sel});
      wr_reg(`ADCS_SEL_ADDR, 8'h47);
      rd_chk("buffer locked", `ADCS_SEL_ADDR, 8'h47);
      rd_chk("applied locked", `ADCS_APPLIED_ADDR, 8'h45);
      wait_done;
      rd_chk("start cleared", `ADCS_CTRL_ADDR, 8'h90);
      rd_chk("applied unlocked", `ADCS_APPLIED_ADDR, 8'h47);
      chk_res(res_of(5'h05));
      wr_reg(`ADCS_CTRL_ADDR, 8'hd0);
      wait_done;
      chk_res(res_of(5'h07));
      // Input above the reference.
      wr_reg(`ADCS_SEL_ADDR, 8'h5e);
      // A slower converter clock here exercises a second prescaler setting.
      wr_reg(`ADCS_CTRL_ADDR, 8'hd2);
      wait_done;
      chk_res(10'h3ff);
      // Free running: the result after a change still carries the old channel.
      wr_reg(`ADCS_SEL_ADDR, 8'h43);
      wr_reg(`ADCS_TRIG_ADDR, 8'h00);
      wr_reg(`ADCS_CTRL_ADDR, 8'hf0);
      wait_done;
      chk_res(res_of(5'h03));
      wr_reg(`ADCS_SEL_ADDR, 8'h46);
      wr_reg(`ADCS_CTRL_ADDR, 8'hf0);
      wait_done;
      chk_res(res_of(5'h03));
      wr_reg(`ADCS_CTRL_ADDR, 8'hf0);
      wait_done;
      chk_res(res_of(5'h06));
      wr_reg(`ADCS_CTRL_ADDR, 8'h00);
      // Pin trigger.
      wr_reg(`ADCS_TRIG_ADDR, 8'h01);
      wr_reg(`ADCS_CTRL_ADDR, 8'hb0);
      @(posedge clock);
      trigger_pin <= 1'b1;
      for (i = 0; i < 20 && conv_busy !== 1'b1; i++) begin
         @(posedge clock);
         #1;
      end
      #1 chk_bit("trigger start", 1'b1, conv_busy);
      @(posedge clock);
      trigger_pin <= 1'b0;
      rd_chk("start bit triggered", `ADCS_CTRL_ADDR, 8'he0);
      wait_done;
      wr_reg(`ADCS_CTRL_ADDR, 8'h00);
      // Noise-reduction sleep wakes on completion; the old done flag is cleared first.
      wr_reg(`ADCS_CTRL_ADDR, 8'h98);
      #1 chk_bit("irq before sleep", 1'b0, irq);
      @(posedge clock);
      sleep_mode <= `ADCS_SLEEP_NOISE;
      cpu_halted <= 1'b1;
      wait_irq;
      @(posedge clock);
      cpu_halted <= 1'b0;
      wr_reg(`ADCS_CTRL_ADDR, 8'h98);
      @(posedge clock);
      #1 chk_bit("irq cleared", 1'b0, irq);
      // Idle sleep left early by another wake source still completes.
      @(posedge clock);
      sleep_mode <= `ADCS_SLEEP_IDLE;
      cpu_halted <= 1'b1;
      repeat (6) @(posedge clock);
      cpu_halted <= 1'b0;
      #1 chk_bit("irq early wake", 1'b0, irq);
      wait_irq;
      wr_reg(`ADCS_CTRL_ADDR, 8'h98);
      // Another sleep kind neither converts nor disables.
      @(posedge clock);
      sleep_mode <= 3'h3;
      cpu_halted <= 1'b1;
      repeat (80) @(posedge clock);
      #1 chk_bit("busy other sleep", 1'b0, conv_busy);
      rd_chk("ctrl other sleep", `ADCS_CTRL_ADDR, 8'h88);
      finish_test;
   end
endmodule

`default_nettype wire

// >>> verilog/adcs_ctrl.sv
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_regs.svh"

// Notes on behaviour
// - Selection bits sit in a software buffer apart from the applied selection.
// - Applied selection follows the buffer while idle and freezes during conversion.
// - Copying resumes in the last converter clock before the done flag sets.
// - A start write begins conversion at the next converter clock edge.
// - A selection written at a safe point applies to the next conversion.
// - Free running: the result after a channel change still uses the old channel.
// - An input above the reference gives a result at full scale.
// - Reference is the analog supply, the internal bandgap or the reference pin.
// - Sleep-time conversion works only in noise-reduction and idle sleep.
// - Entering those sleeps starts a conversion once the core halts, with auto triggering off.
// - The completion interrupt wakes the core.
// - Completion still raises its request if another interrupt woke the core.
// - Other sleep modes never switch the converter off.
// - The start bit reads one during conversion; hardware clears it at the end except when free running.
// - An accepted trigger edge resets the prescaler and starts a conversion.

module adcs_ctrl (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Register port.
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // Core sleep status and interrupt request.
   input wire logic cpu_halted,
   input wire logic [2:0] sleep_mode,
   output logic irq,
   // Auto trigger pin.
   input wire logic trigger_pin,
   // Analog converter side.
   input wire logic [9:0] analog_result,
   input wire logic over_range,
   output logic [4:0] chan_sel,
   output logic ref_supply_en,
   output logic ref_bandgap_en,
   output logic ref_pin_en,
   output logic sample_hold,
   output logic conv_busy
);

   adcs_pkg::adcs_state_t state;
   adcs_pkg::adcs_state_t next_state;
   adcs_pkg::adcs_sel_t sel_buf;
   adcs_pkg::adcs_sel_t next_sel_buf;
   adcs_pkg::adcs_sel_t applied;
   adcs_pkg::adcs_sel_t next_applied;
   adcs_pkg::adcs_ctrl_t ctrl;
   adcs_pkg::adcs_ctrl_t next_ctrl;
   logic [4:0] cnt;
   logic [4:0] next_cnt;
   logic start_bit;
   logic next_start_bit;
   logic done_flag;
   logic next_done_flag;
   logic first;
   logic next_first;
   logic trig_src;
   logic next_trig_src;
   logic halted_prev;
   logic [9:0] result;
   logic [9:0] next_result;
   logic [7:0] next_rdata;
   logic next_sample_hold;
   logic tick;
   logic trig_rise;
   logic presc_clear;
   logic last_cycle;
   logic locked;
   logic conv_end;
   logic free_run;
   logic sleep_start;
   logic trig_start;
   logic sw_start;
   logic [4:0] conv_len;
   logic [4:0] sh_pos;

   // Reference code to source enables; the reserved code leaves only the pin.
   function automatic logic [2:0] ref_decode(input logic [1:0] code);
      case (code)
         `ADCS_REF_SUPPLY: ref_decode = 3'h4;
         `ADCS_REF_BANDGAP: ref_decode = 3'h2;
         default: ref_decode = 3'h1;
      endcase
   endfunction

   adcs_prescale u_prescale (
      .clock(clock),
      .rst(rst),
      .run(ctrl.en),
      .clear(presc_clear),
      .ps(ctrl.ps),
      .tick(tick)
   );

   adcs_trig_sync u_trig (
      .clock(clock),
      .rst(rst),
      .trigger_pin(trigger_pin),
      .trig_rise(trig_rise)
   );

   // Conversion timing; the first one after enabling is longer.
   assign conv_len = first ? `ADCS_FIRST_CYCLES : `ADCS_CONV_CYCLES;
   assign sh_pos = first ? `ADCS_SH_FIRST : `ADCS_SH_NORMAL;
   assign last_cycle = (state == adcs_pkg::ADCS_CONV) && (cnt == 5'(conv_len - 5'h01));
   assign conv_end = last_cycle && tick;
   // Lock spans the conversion except its final converter clock.
   assign locked = (state == adcs_pkg::ADCS_CONV) && !last_cycle;
   assign free_run = ctrl.auto_trig && !trig_src;

   // Start sources, each only from an idle converter.
   assign sw_start = wr && (addr == `ADCS_CTRL_ADDR) && wdata[`ADCS_CTRL_EN]
      && wdata[`ADCS_CTRL_START] && (state == adcs_pkg::ADCS_IDLE);
   // A sleep entry with the core halted starts a conversion; software sets up the rest.
   assign sleep_start = ctrl.en && !ctrl.auto_trig && cpu_halted && !halted_prev
      && ((sleep_mode == `ADCS_SLEEP_IDLE) || (sleep_mode == `ADCS_SLEEP_NOISE))
      && (state == adcs_pkg::ADCS_IDLE) && !sw_start;
   // Pin edges count only with the flag cleared; edges during conversion are ignored.
   assign trig_start = ctrl.en && ctrl.auto_trig && trig_src && trig_rise && !done_flag
      && (state == adcs_pkg::ADCS_IDLE) && !sw_start && !sleep_start;
   assign presc_clear = trig_start;

   // Sequencer, control bits, selection buffer and result.
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_start_bit = start_bit;
      next_done_flag = done_flag;
      next_first = first;
      next_ctrl = ctrl;
      next_trig_src = trig_src;
      next_sel_buf = sel_buf;
      next_result = result;
      next_sample_hold = 1'b0;
      // Software writes land in the buffer at any time, frozen or not.
      if (wr && (addr == `ADCS_SEL_ADDR)) begin
         next_sel_buf.ref_code = wdata[`ADCS_SEL_REF_MSB:`ADCS_SEL_REF_LSB];
         next_sel_buf.chan = wdata[`ADCS_SEL_CHAN_MSB:`ADCS_SEL_CHAN_LSB];
      end
      if (wr && (addr == `ADCS_TRIG_ADDR)) begin
         next_trig_src = wdata[`ADCS_TRIG_SRC];
      end
      // Sleep entry never touches the enable; only software clears it.
      if (wr && (addr == `ADCS_CTRL_ADDR)) begin
         next_ctrl.en = wdata[`ADCS_CTRL_EN];
         next_ctrl.auto_trig = wdata[`ADCS_CTRL_AUTO];
         next_ctrl.ie = wdata[`ADCS_CTRL_IE];
         next_ctrl.ps = wdata[`ADCS_CTRL_PS_MSB:`ADCS_CTRL_PS_LSB];
         if (wdata[`ADCS_CTRL_DONE]) begin
            next_done_flag = 1'b0;
         end
      end
      case (state)
         adcs_pkg::ADCS_IDLE: begin
            if (sw_start || sleep_start || trig_start) begin
               next_start_bit = 1'b1;
               next_state = adcs_pkg::ADCS_PEND;
            end
         end
         adcs_pkg::ADCS_PEND: begin
            // The write cycle only arms; the converter clock edge begins the work.
            if (tick) begin
               next_state = adcs_pkg::ADCS_CONV;
               next_cnt = 5'h00;
            end
         end
         adcs_pkg::ADCS_CONV: begin
            if (tick) begin
               next_cnt = 5'(cnt + 5'h01);
               next_sample_hold = (cnt == sh_pos);
            end
            if (conv_end) begin
               next_first = 1'b0;
               next_cnt = 5'h00;
               // Completion request stands even if another wake came first.
               next_done_flag = 1'b1;
               next_result = over_range ? `ADCS_FULL_SCALE : analog_result;
               if (free_run) begin
                  // Chained conversion already locked the selection it copied last cycle.
                  next_state = adcs_pkg::ADCS_CONV;
               end else begin
                  next_start_bit = 1'b0;
                  next_state = adcs_pkg::ADCS_IDLE;
               end
            end
         end
         default: begin
            next_state = adcs_pkg::ADCS_IDLE;
         end
      endcase
      // Switching off aborts any conversion and rearms the long first one.
      if (!next_ctrl.en) begin
         next_state = adcs_pkg::ADCS_IDLE;
         next_start_bit = 1'b0;
         next_first = 1'b1;
         next_cnt = 5'h00;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= adcs_pkg::ADCS_IDLE;
         cnt <= 5'h00;
         start_bit <= 1'b0;
         done_flag <= 1'b0;
         first <= 1'b1;
         ctrl <= adcs_pkg::adcs_ctrl_t'(6'h00);
         trig_src <= 1'(`ADCS_TRIG_RESET);
         sel_buf <= adcs_pkg::adcs_sel_t'(7'h00);
         result <= 10'h000;
         sample_hold <= 1'b0;
         halted_prev <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         start_bit <= next_start_bit;
         done_flag <= next_done_flag;
         first <= next_first;
         ctrl <= next_ctrl;
         trig_src <= next_trig_src;
         sel_buf <= next_sel_buf;
         result <= next_result;
         sample_hold <= next_sample_hold;
         halted_prev <= cpu_halted;
      end
   end

   // Applied selection: follows the buffer unless locked, so the next conversion sees it.
   always_comb begin
      next_applied = locked ? applied : sel_buf;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         applied <= adcs_pkg::adcs_sel_t'(7'h00);
      end else begin
         applied <= next_applied;
      end
   end

   // Read data register; unmapped offsets read zero.
   always_comb begin
      next_rdata = 8'h00;
      if (rd) begin
         case (addr)
            `ADCS_SEL_ADDR: next_rdata = {sel_buf.ref_code, 1'b0, sel_buf.chan};
            `ADCS_CTRL_ADDR: next_rdata = {ctrl.en, start_bit, ctrl.auto_trig, done_flag,
               ctrl.ie, ctrl.ps};
            `ADCS_TRIG_ADDR: next_rdata = {7'h00, trig_src};
            `ADCS_APPLIED_ADDR: next_rdata = {applied.ref_code, 1'b0, applied.chan};
            `ADCS_RES_LO_ADDR: next_rdata = result[7:0];
            `ADCS_RES_HI_ADDR: next_rdata = {6'h00, result[9:8]};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata <= `ADCS_CTRL_RESET;
      end else begin
         rdata <= next_rdata;
      end
   end

   // Outputs to the analog side; the reference enables are held off while the converter is disabled.
   assign chan_sel = applied.chan;
   assign {ref_supply_en, ref_bandgap_en, ref_pin_en} =
      ctrl.en ? ref_decode(applied.ref_code) : 3'h0;
   assign conv_busy = (state == adcs_pkg::ADCS_CONV);
   // The interrupt level doubles as the core's wake request.
   assign irq = done_flag && ctrl.ie;

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   a_lock_holds: assert property (locked |=> $stable(applied))
      else $error("applied selection moved while locked");
   a_copy_free: assert property (!locked |=> applied == $past(sel_buf))
      else $error("applied selection missed buffer copy");
   a_unlock_last: assert property (last_cycle |-> !locked)
      else $error("selection still locked in last cycle");
   a_start_tick: assert property ($rose(conv_busy) |-> $past(tick))
      else $error("conversion began off a converter clock edge");
   a_done_clear: assert property (conv_end && !free_run |=> !start_bit && done_flag)
      else $error("start bit not cleared at completion");
   a_busy_start: assert property (conv_busy |-> start_bit)
      else $error("start bit low during conversion");
   a_full_scale: assert property (conv_end && over_range |=> result == 10'h3ff)
      else $error("over range result not full scale");
   a_sleep_go: assert property (sleep_start |=> start_bit ##[1:256] conv_busy)
      else $error("sleep entry did not start conversion");
   a_ref_onehot: assert property ($onehot0({ref_supply_en, ref_bandgap_en, ref_pin_en}))
      else $error("more than one reference source on");
   a_irq_done: assert property (conv_end && ctrl.ie && ctrl.en |=> irq)
      else $error("completion interrupt not raised");
   a_trig_pend: assert property (trig_start |=> state == adcs_pkg::ADCS_PEND)
      else $error("trigger edge did not start conversion");

endmodule
`default_nettype wire

// >>> verilog/adcs_prescale.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcs_regs.svh"

module adcs_prescale (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Control.
   input wire logic run,
   input wire logic clear,
   input wire logic [2:0] ps,
   // Converter clock rising edge, one cycle pulse.
   output logic tick
);

   logic [6:0] cnt;
   logic [6:0] next_cnt;

   // Division ratio minus one; codes 0 and 1 both divide by two.
   function automatic logic [6:0] last_count(input logic [2:0] code);
      logic [7:0] div;
      div = (code == 3'h0) ? 8'h02 : (8'h01 << code);
      last_count = 7'(div - 8'h01);
   endfunction

   // The counter is held at zero while the converter is off or a trigger resets it.
   always_comb begin
      tick = run && !clear && (cnt == last_count(ps));
      if (!run || clear || tick) begin
         next_cnt = 7'h00;
      end else begin
         next_cnt = 7'(cnt + 7'h01);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt <= 7'h00;
      end else begin
         cnt <= next_cnt;
      end
   end

   // A trigger restart always leaves the counter at zero.
   a_clear_zero: assert property (@(posedge clock) disable iff (rst) clear |=> cnt == 7'h00)
      else $error("prescaler not reset by trigger");

endmodule
`default_nettype wire

// >>> verilog/adcs_trig_sync.sv
`timescale 1ns/1ps
`default_nettype none

module adcs_trig_sync (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Asynchronous trigger pin.
   input wire logic trigger_pin,
   // Rising edge of the synchronised trigger.
   output logic trig_rise
);

   logic sync_a;
   logic sync_b;
   logic sync_prev;

   // Two stages before anything looks at the pin; the third flop feeds the edge detector.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         sync_prev <= 1'b0;
      end else begin
         sync_a <= trigger_pin;
         sync_b <= sync_a;
         sync_prev <= sync_b;
      end
   end

   assign trig_rise = sync_b && !sync_prev;

endmodule
`default_nettype wire
